// [verilog/exec_core.sv]
// Instruction execution core with its AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module exec_core #(
  parameter int unsigned ADDR_W = 8             // AXI address width
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   watchdog_counter_clear,
  output logic                   watchdog_prescaler_clear
);
  import exec_pkg::*;

  // Refuse address widths too narrow for the map
  if (ADDR_W < OFF_W) begin : g_bad_addr_w
    $error("exec_core: ADDR_W must be at least 8");
  end

  // Bus side state
  logic                 awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]           bresp_reg, rresp_reg;
  logic [31:0]          rdata_reg;
  logic                 aw_held_reg, w_held_reg;
  logic [7:0]           aw_addr_reg;      // Held write address
  logic [31:0]          w_data_reg;       // Held write data
  logic [3:0]           w_strb_reg;       // Held byte strobes

  // Core state
  exec_state_t          state_reg;
  instr_t               instr_reg;        // Instruction being executed
  alu_out_t             fx;               // Its decoded effects
  logic [7:0]           acc_reg;          // Accumulator
  logic [PC_W-1:0]      program_counter_reg;
  logic [4:0]           pc_high_latch_reg;
  logic [PC_W-1:0]      stack_top_entry_reg;
  logic [FILE_AW-1:0]   file_index_reg;   // Software window into the file
  logic                 zero_reg, powerdown_flag_reg, watchdog_expired_flag_reg;
  logic                 skip_reg;         // Last decrement-skip took the skip
  logic [31:0]          cycles_reg;       // Instruction cycles executed
  logic                 wdt_clear_reg;
  logic [7:0]           file_mem [FILE_N];  // File registers

  // Handshake terms
  logic aw_take, w_take, ar_take, write_do;
  logic aw_held_next, w_held_next, bvalid_next, rvalid_next;

  assign aw_take      = awvalid & awready_reg;
  assign w_take       = wvalid & wready_reg;
  assign ar_take      = arvalid & arready_reg;
  // Writes wait while an instruction runs, so software never races it
  assign write_do     = aw_held_reg & w_held_reg & ~bvalid_reg & (state_reg == ST_IDLE);
  assign aw_held_next = (aw_held_reg | aw_take) & ~write_do;
  assign w_held_next  = (w_held_reg | w_take) & ~write_do;
  assign bvalid_next  = write_do | (bvalid_reg & ~bready);
  assign rvalid_next  = ar_take | (rvalid_reg & ~rready);

  // Register image shared by reads and write merging
  logic [31:0] status_word;
  assign status_word = {27'h0000000, watchdog_expired_flag_reg, powerdown_flag_reg,
                        skip_reg, (state_reg != ST_IDLE), zero_reg};

  function automatic logic [32:0] reg_value(input logic [7:0] a);
    logic [32:0] v;
    v = {1'b1, 32'h00000000};
    case (a)
      OFF_INSTR:  v[31:0] = {{(32-INSTR_W){1'b0}}, instr_reg};
      OFF_STATUS: v[31:0] = status_word;
      OFF_ACC:    v[7:0]  = acc_reg;
      OFF_PC:     v[PC_W-1:0] = program_counter_reg;
      OFF_LATCH:  v[4:0]  = pc_high_latch_reg;
      OFF_STACK:  v[PC_W-1:0] = stack_top_entry_reg;
      OFF_FINDEX: v[FILE_AW-1:0] = file_index_reg;
      OFF_FDATA:  v[7:0]  = file_mem[file_index_reg];
      OFF_CYCLES: v[31:0] = cycles_reg;
      default:    v = '0;                       // Unmapped
    endcase
    return v;
  endfunction : reg_value

  // Write decode
  logic [32:0] wr_look;
  logic [31:0] wr_data;
  logic        wr_err, sw_wr;
  logic        wr_is_instr, wr_is_status, wr_is_acc, wr_is_pc, wr_is_latch;
  logic        wr_is_findex, wr_is_fdata;
  logic [32:0] rd_look;

  // The function reads module state beyond its argument; an assign would only
  // wake on the address and could hand back a stale register image
  always_comb begin
    wr_look = reg_value(aw_addr_reg);
    rd_look = reg_value(araddr[7:0]);
  end
  // Lanes without a strobe keep their old contents
  for (genvar gb = 0; gb < 4; gb++) begin : g_lane
    assign wr_data[gb*8 +: 8] = w_strb_reg[gb] ? w_data_reg[gb*8 +: 8] : wr_look[gb*8 +: 8];
  end
  assign wr_is_instr  = (aw_addr_reg == OFF_INSTR);
  assign wr_is_status = (aw_addr_reg == OFF_STATUS);
  assign wr_is_acc    = (aw_addr_reg == OFF_ACC);
  assign wr_is_pc     = (aw_addr_reg == OFF_PC);
  assign wr_is_latch  = (aw_addr_reg == OFF_LATCH);
  assign wr_is_findex = (aw_addr_reg == OFF_FINDEX);
  assign wr_is_fdata  = (aw_addr_reg == OFF_FDATA);
  // Unmapped address or reserved operation code answers SLVERR
  assign wr_err = ~wr_look[32] | (wr_is_instr & (wr_data[2:0] == OP_RESERVED));
  assign sw_wr  = write_do & ~wr_err;

  // Execution terms
  logic exec_go, issue;
  logic [7:0] operand;
  assign exec_go = (state_reg == ST_EXEC);
  assign issue   = sw_wr & wr_is_instr;
  assign operand = file_mem[instr_reg.file_addr];

  exec_alu u_alu (
    .instr   (instr_reg),
    .operand (operand),
    .fx      (fx)
  );

  // AXI write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      awready_reg <= ~aw_held_next;
      wready_reg  <= ~w_held_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      bvalid_reg  <= bvalid_next;
      if (write_do) begin
        bresp_reg <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Write payload capture; no reset needed, guarded by the held flags
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_reg <= awaddr[7:0];
    end
    if (w_take) begin
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
  end

  // AXI read channel; one read in flight, data latched at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_look[31:0];
        rresp_reg <= rd_look[32] ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Sequencer: a jump or a taken skip holds a second cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:   state_reg <= issue ? ST_EXEC : ST_IDLE;
        ST_EXEC:   state_reg <= (fx.call | fx.skip) ? ST_SECOND : ST_IDLE;
        ST_SECOND: state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Issued word and cycle count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg  <= '0;
      cycles_reg <= 32'h00000000;
    end else begin
      if (issue) begin
        instr_reg <= wr_data[INSTR_W-1:0];
      end
      if (state_reg != ST_IDLE) begin
        cycles_reg <= cycles_reg + 32'h00000001;
      end
    end
  end

  // Program counter and return stack top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_counter_reg <= PC_RESET;
      stack_top_entry_reg <= PC_RESET;
    end else if (exec_go && fx.call) begin
      stack_top_entry_reg <= program_counter_reg + PC_STEP;
      program_counter_reg <= {pc_high_latch_reg[LATCH_HI:LATCH_LO],
                              instr_reg.target};
    end else if (exec_go) begin
      program_counter_reg <= program_counter_reg + PC_STEP;
    end else if (state_reg == ST_SECOND && instr_reg.op == OP_DECREMENT_SKIP) begin
      // Skip flag outlives its instruction, so a jump's second cycle must not step
      program_counter_reg <= program_counter_reg + PC_STEP;   // Discarded slot
    end else if (sw_wr && wr_is_pc) begin
      program_counter_reg <= wr_data[PC_W-1:0];
    end
  end

  // Accumulator, latch and file window index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg           <= ACC_RESET;
      pc_high_latch_reg <= LATCH_RESET;
      file_index_reg    <= '0;
    end else begin
      if (exec_go && fx.acc_we) begin
        acc_reg <= fx.result;
      end else if (sw_wr && wr_is_acc) begin
        acc_reg <= wr_data[7:0];
      end
      if (sw_wr && wr_is_latch) begin
        pc_high_latch_reg <= wr_data[4:0];
      end
      if (sw_wr && wr_is_findex) begin
        file_index_reg <= wr_data[FILE_AW-1:0];
      end
    end
  end

  // File registers; plain storage, contents undefined after power-up
  always_ff @(posedge aclk) begin
    if (exec_go && fx.file_we) begin
      file_mem[instr_reg.file_addr] <= fx.result;
    end else if (sw_wr && wr_is_fdata) begin
      file_mem[file_index_reg] <= wr_data[7:0];
    end
  end

  // Status flags; hardware and software never write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_reg                  <= ZERO_RESET;
      powerdown_flag_reg        <= PD_RESET;
      watchdog_expired_flag_reg <= EXPIRED_RESET;
      skip_reg                  <= 1'b0;
    end else if (exec_go) begin
      if (fx.zero_we) begin                                    // Never on skip form
        zero_reg <= fx.zero;
      end
      if (fx.wdt_clear) begin
        powerdown_flag_reg        <= 1'b1;
        watchdog_expired_flag_reg <= 1'b1;
      end
      if (instr_reg.op == OP_DECREMENT_SKIP) begin
        skip_reg <= fx.skip;
      end
    end else if (sw_wr && wr_is_status) begin
      zero_reg                  <= wr_data[ST_ZERO_BIT];
      powerdown_flag_reg        <= wr_data[ST_PD_BIT];
      watchdog_expired_flag_reg <= wr_data[ST_EXPIRED_BIT];
    end
  end

  // Watchdog clears go out as one-cycle pulses to the timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_clear_reg <= 1'b0;
    end else begin
      wdt_clear_reg <= exec_go & fx.wdt_clear;
    end
  end

  // Outputs straight from flip-flops
  assign awready                  = awready_reg;
  assign wready                   = wready_reg;
  assign bvalid                   = bvalid_reg;
  assign bresp                    = bresp_reg;
  assign arready                  = arready_reg;
  assign rvalid                   = rvalid_reg;
  assign rdata                    = rdata_reg;
  assign rresp                    = rresp_reg;
  assign watchdog_counter_clear   = wdt_clear_reg;
  assign watchdog_prescaler_clear = wdt_clear_reg;

endmodule : exec_core

// [verilog/exec_pkg.sv]
// Shared constants, types and register map of the instruction execution block
package exec_pkg;

  // Bus shape and core widths
  localparam int unsigned DATA_W   = 32;          // AXI data width
  localparam int unsigned OFF_W    = 8;           // Decoded low address bits
  localparam int unsigned PC_W     = 13;          // Program counter width
  localparam int unsigned TARGET_W = 11;          // Immediate jump target width
  localparam int unsigned FILE_AW  = 7;           // File register address width
  localparam int unsigned FILE_N   = 128;         // Number of file registers

  // Register byte offsets
  localparam logic [7:0] OFF_INSTR  = 8'h00;      // Instruction issue word
  localparam logic [7:0] OFF_STATUS = 8'h04;      // Flags and busy
  localparam logic [7:0] OFF_ACC    = 8'h08;      // Accumulator
  localparam logic [7:0] OFF_PC     = 8'h0c;      // Program counter
  localparam logic [7:0] OFF_LATCH  = 8'h10;      // Program counter high latch
  localparam logic [7:0] OFF_STACK  = 8'h14;      // Return stack top entry
  localparam logic [7:0] OFF_FINDEX = 8'h18;      // File window index
  localparam logic [7:0] OFF_FDATA  = 8'h1c;      // File window data
  localparam logic [7:0] OFF_CYCLES = 8'h20;      // Instruction cycle count

  // Status field positions
  localparam int unsigned ST_ZERO_BIT    = 0;     // Zero flag
  localparam int unsigned ST_BUSY_BIT    = 1;     // Execution under way
  localparam int unsigned ST_SKIP_BIT    = 2;     // Last decrement skipped
  localparam int unsigned ST_PD_BIT      = 3;     // Power-down flag
  localparam int unsigned ST_EXPIRED_BIT = 4;     // Watchdog expired flag

  // Reset values
  localparam logic [7:0]      ACC_RESET     = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET      = 13'h0000;
  localparam logic [4:0]      LATCH_RESET   = 5'h00;
  localparam logic            ZERO_RESET    = 1'b0;
  localparam logic            PD_RESET      = 1'b1;
  localparam logic            EXPIRED_RESET = 1'b1;

  // Fixed values of the instruction set
  localparam logic [7:0]      CLEARED_VALUE = 8'h00;  // Result of the clear forms
  localparam logic [7:0]      DECREMENT     = 8'h01;  // Step of the decrement forms
  localparam logic [PC_W-1:0] PC_STEP       = 13'h0001;
  localparam int unsigned     LATCH_HI      = 4;      // Latch bits copied on a jump
  localparam int unsigned     LATCH_LO      = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Operation codes carried in the issue word
  typedef enum logic [2:0] {
    OP_WATCHDOG_CLEAR   = 3'h0,   // watchdog_clear_op
    OP_SUBROUTINE_CALL  = 3'h1,   // Subroutine jump
    OP_COMPLEMENT_FILE  = 3'h2,   // complement_file_op
    OP_CLEAR_FILE       = 3'h3,   // clear_file_op
    OP_CLEAR_ACC        = 3'h4,   // clear_accumulator_op
    OP_DECREMENT_FILE   = 3'h5,   // decrement_file_op
    OP_DECREMENT_SKIP   = 3'h6,   // decrement_skip_zero_op
    OP_RESERVED         = 3'h7    // Refused
  } instr_op_t;

  // Execution sequence, one bit changes per step except SECOND to IDLE
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_SECOND = 2'b11
  } exec_state_t;

  // Issue word layout, low bits first: op, dest, file address, target
  typedef struct packed {
    logic [TARGET_W-1:0] target;
    logic [FILE_AW-1:0]  file_addr;
    logic                dest;
    instr_op_t           op;
  } instr_t;

  localparam int unsigned INSTR_W = $bits(instr_t);

  // Decoded effects of one instruction
  typedef struct packed {
    logic [7:0] result;     // Value to write
    logic       zero;       // New zero flag value
    logic       zero_we;    // Zero flag is updated
    logic       acc_we;     // Result goes to the accumulator
    logic       file_we;    // Result goes to the file register
    logic       skip;       // Next slot becomes a no-operation
    logic       call;       // Subroutine jump
    logic       wdt_clear;  // Watchdog clear
  } alu_out_t;

endpackage : exec_pkg

// [verilog/exec_alu.sv]
// Combinational decode and data path for one issued instruction
`timescale 1ns/100ps
module exec_alu (
  input  exec_pkg::instr_t   instr,
  input  wire logic [7:0]    operand,
  output exec_pkg::alu_out_t fx
);
  import exec_pkg::*;

  logic [7:0] dec_value;   // Operand minus one, wraps at zero
  logic [7:0] inv_value;   // Operand inverted

  assign dec_value = operand - DECREMENT;
  assign inv_value = ~operand;

  // Effects per operation; every field has a value on every path
  always_comb begin
    fx = '0;
    case (instr.op)
      OP_WATCHDOG_CLEAR: begin
        fx.wdt_clear = 1'b1;
      end
      OP_SUBROUTINE_CALL: begin
        fx.call = 1'b1;                       // No flag touched
      end
      OP_COMPLEMENT_FILE: begin
        fx.result  = inv_value;
        fx.zero    = (inv_value == CLEARED_VALUE);
        fx.zero_we = 1'b1;
        fx.acc_we  = ~instr.dest;
        fx.file_we = instr.dest;
      end
      OP_CLEAR_FILE: begin
        fx.result  = CLEARED_VALUE;
        fx.zero    = 1'b1;
        fx.zero_we = 1'b1;
        fx.file_we = 1'b1;
      end
      OP_CLEAR_ACC: begin
        fx.result  = CLEARED_VALUE;
        fx.zero    = 1'b1;
        fx.zero_we = 1'b1;
        fx.acc_we  = 1'b1;
      end
      OP_DECREMENT_FILE: begin
        fx.result  = dec_value;
        fx.zero    = (dec_value == CLEARED_VALUE);
        fx.zero_we = 1'b1;
        fx.acc_we  = ~instr.dest;
        fx.file_we = instr.dest;
      end
      OP_DECREMENT_SKIP: begin
        fx.result  = dec_value;               // Zero flag untouched
        fx.acc_we  = ~instr.dest;
        fx.file_we = instr.dest;
        fx.skip    = (dec_value == CLEARED_VALUE);
      end
      default: begin
        fx = '0;                              // Reserved code does nothing
      end
    endcase
  end

endmodule : exec_alu

// [sim/exec_core_asserts.sv]
// Port-level assertions for the instruction execution core
`timescale 1ns/100ps
module exec_core_chk
  import exec_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        watchdog_counter_clear,
  input wire logic        watchdog_prescaler_clear
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both clear outputs always move together
  property p_clr_pair; watchdog_counter_clear == watchdog_prescaler_clear; endproperty
  a_clr_pair: assert property (p_clr_pair) else $error("clear outputs differ");
  // One instruction gives exactly one pulse, never a stretched one
  property p_clr_pulse; watchdog_counter_clear |=> !watchdog_counter_clear; endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
  // A clear only follows an accepted write
  property p_clr_cause;
    $rose(watchdog_counter_clear) |-> $past(bvalid) && $past(bresp) == RESP_OKAY;
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("clear without a write");
  // Write answer comes within the idle wait bound
  property p_wans; awvalid && awready && wvalid && wready |-> ##[1:5] bvalid; endproperty
  a_wans: assert property (p_wans) else $error("write answer late");
  // Write answer stands until taken
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  // Read answer one cycle after the take
  property p_rans; arvalid && arready |=> rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  // Read data stands until taken
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  // Refused reads carry no data
  property p_rerr; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
  a_rerr: assert property (p_rerr) else $error("refused read has data");
  // Address channel closes after a take
  property p_aw_once; awvalid && awready |=> !awready; endproperty
  a_aw_once: assert property (p_aw_once) else $error("second address taken");

  c_clr: cover property (watchdog_counter_clear);
  c_werr: cover property (bvalid && bresp == RESP_SLVERR);
  c_rerr: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : exec_core_chk

bind exec_core exec_core_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .watchdog_counter_clear(watchdog_counter_clear),
  .watchdog_prescaler_clear(watchdog_prescaler_clear));

// [sim/tb.sv]
// Directed register-level test of the instruction execution core
`timescale 1ns/100ps
`define check_eq(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  import exec_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv, c0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, clr_cnt, clr_pre;
  logic [1:0]  bresp, rresp, rs;
  int          bad_count = 0, check_count = 0, cyc = 0, n_clr = 0, n_pre = 0;
  logic [4:0]  lt [2] = '{5'h18, 5'h17};     // Latch values, low bits must not leak
  logic [10:0] tg [2] = '{11'h7ff, 11'h000};  // Extreme jump targets
  logic [12:0] ep [2] = '{13'h1fff, 13'h1000};

  exec_core i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .watchdog_counter_clear(clr_cnt), .watchdog_prescaler_clear(clr_pre));

  initial forever #10 aclk = ~aclk;

  // Count clear pulses and cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (clr_cnt === 1'b1) n_clr++;
    if (clr_pre === 1'b1) n_pre++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready && !aw_done) begin aw_done = 1; awvalid <= 0; end
      if (wready && !w_done) begin w_done = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `check_eq(r, RESP_OKAY)
    `check_eq(d, e)
  endtask : chk

  // Issue one instruction, then poll until the core is idle again
  task automatic issue(input instr_op_t o, input logic dst, input logic [6:0] fa,
                       input logic [10:0] t);
    instr_t      w;
    logic [1:0]  r;
    logic [31:0] s;
    w = '{target: t, file_addr: fa, dest: dst, op: o};
    wr(OFF_INSTR, 32'(w), r);
    `check_eq(r, RESP_OKAY)
    do rd(OFF_STATUS, s, r); while (s[ST_BUSY_BIT] !== 1'b0);
  endtask : issue

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    chk(OFF_STATUS, 32'h18);
    // Watchdog clear raises both flags, keeps zero
    wr(OFF_STATUS, 32'h01, rs);
    issue(OP_WATCHDOG_CLEAR, 0, 0, 0);
    `check_eq(n_clr, 1)
    `check_eq(n_pre, 1)
    chk(OFF_STATUS, 32'h19);
    // Complement at the top file address, both destinations
    wr(OFF_FINDEX, 32'h7f, rs);
    wr(OFF_FDATA, 32'h5a, rs);
    issue(OP_COMPLEMENT_FILE, 1, 7'h7f, 0);
    chk(OFF_FDATA, 32'ha5);
    chk(OFF_STATUS, 32'h18);
    issue(OP_COMPLEMENT_FILE, 0, 7'h7f, 0);
    chk(OFF_ACC, 32'h5a);
    chk(OFF_FDATA, 32'ha5);
    wr(OFF_FDATA, 32'hff, rs);
    issue(OP_COMPLEMENT_FILE, 0, 7'h7f, 0);
    chk(OFF_STATUS, 32'h19);
    // Clear file hits only the addressed register
    wr(OFF_FINDEX, 32'h00, rs);
    wr(OFF_FDATA, 32'h3c, rs);
    wr(OFF_FINDEX, 32'h7f, rs);
    wr(OFF_STATUS, 32'h18, rs);
    issue(OP_CLEAR_FILE, 0, 7'h7f, 0);
    chk(OFF_FDATA, 32'h00);
    chk(OFF_STATUS, 32'h19);
    wr(OFF_FINDEX, 32'h00, rs);
    chk(OFF_FDATA, 32'h3c);
    // Clear accumulator
    wr(OFF_ACC, 32'h77, rs);
    wr(OFF_STATUS, 32'h18, rs);
    issue(OP_CLEAR_ACC, 0, 0, 0);
    chk(OFF_ACC, 32'h00);
    chk(OFF_STATUS, 32'h19);
    // Decrement to zero, then wrap from zero
    wr(OFF_FDATA, 32'h01, rs);
    wr(OFF_STATUS, 32'h18, rs);
    issue(OP_DECREMENT_FILE, 0, 0, 0);
    chk(OFF_ACC, 32'h00);
    chk(OFF_FDATA, 32'h01);
    chk(OFF_STATUS, 32'h19);
    wr(OFF_FDATA, 32'h00, rs);
    issue(OP_DECREMENT_FILE, 1, 0, 0);
    chk(OFF_FDATA, 32'hff);
    chk(OFF_STATUS, 32'h18);
    // Subroutine jump with extreme targets
    for (int i = 0; i < 2; i++) begin
      wr(OFF_LATCH, {27'h0, lt[i]}, rs);
      wr(OFF_PC, 32'h123, rs);
      rd(OFF_CYCLES, c0, rs);
      issue(OP_SUBROUTINE_CALL, 0, 0, tg[i]);
      chk(OFF_PC, {19'h0, ep[i]});
      chk(OFF_STACK, 32'h124);
      chk(OFF_CYCLES, c0 + 32'h2);
      chk(OFF_STATUS, 32'h18);
    end
    // Decrement-skip: no skip, then skip
    wr(OFF_PC, 32'h10, rs);
    wr(OFF_FDATA, 32'h02, rs);
    wr(OFF_STATUS, 32'h19, rs);
    rd(OFF_CYCLES, c0, rs);
    issue(OP_DECREMENT_SKIP, 1, 0, 0);
    chk(OFF_FDATA, 32'h01);
    chk(OFF_PC, 32'h11);
    chk(OFF_CYCLES, c0 + 32'h1);
    chk(OFF_STATUS, 32'h19);
    wr(OFF_ACC, 32'h55, rs);
    rd(OFF_CYCLES, c0, rs);
    issue(OP_DECREMENT_SKIP, 0, 0, 0);
    chk(OFF_ACC, 32'h00);
    chk(OFF_PC, 32'h13);
    chk(OFF_CYCLES, c0 + 32'h2);
    chk(OFF_STATUS, 32'h1d);
    // Jump right after a taken skip: its second cycle must not step the counter
    wr(OFF_LATCH, 32'h0, rs);
    issue(OP_SUBROUTINE_CALL, 0, 0, 11'h055);
    chk(OFF_PC, 32'h55);
    chk(OFF_STACK, 32'h14);
    // Refused operation code and unmapped read
    wr(OFF_INSTR, 32'h7, rs);
    `check_eq(rs, RESP_SLVERR)
    rd(8'h24, rv, rs);
    `check_eq(rs, RESP_SLVERR)
    `check_eq(rv, 32'h0)
    summarize();
  end
endmodule : tb
